// [logic/pic_initiator_ctrl.v]
// Implementation choice: strobed register access.
`include "pic_defs.vh"
`default_nettype none

module pic_initiator_ctrl #(
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk,
    input wire rst_b,
    input wire [31:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata_q,
    input wire mmReq,
    input wire mmWrite,
    input wire [31:0] mmAddr,
    input wire [31:0] mmWdata,
    output reg mmDone_q,
    output reg [31:0] mmRdata_q,
    input wire [31:0] txData,
    input wire txValid,
    output reg txReady_q,
    output reg [31:0] rxData_q,
    output reg rxValid_q,
    input wire rxReady,
    output reg [7:0] window1Page_q,
    output reg initError_q,
    input wire pciClk,
    input wire pciTrdy,
    input wire [31:0] pciAdIn,
    input wire sysEnPin,
    output reg pciFrame_q,
    output reg pciIrdy_q,
    output reg [3:0] pciCmd_q,
    output reg [31:0] pciAdOut_q,
    output reg pciAdOe_q
);

    reg rstS1, rstS2;
    wire rstN = rstS2;
    reg clkS1, clkS2, clkS3;
    reg trdyS1, trdyS2, sysS1, sysS2;
    reg [31:0] adS1, adS2;
    wire pciRise = clkS2 & ~clkS3;

    reg [31:0] startAddr_q, dmaCfg_q, tpa_q;
    reg [1:0] cmdHi_q;
    reg mode_q;
    reg [3:0] cs_q, ds_q;
    reg dmaPend_q, mmPend_q, mmWr_q, isDma_q, isWrite_q;
    reg [31:0] mmA_q, mmD_q;
    reg [7:0] left_q;
    reg [31:0] txMem [0:DEPTH-1];
    reg [31:0] rxMem [0:DEPTH-1];
    reg [AW-1:0] txWp_q, txRp_q, rxWp_q, rxRp_q;
    reg [AW:0] txCnt_q, rxCnt_q;
    reg [AW:0] txCnt_d, rxCnt_d;
    wire [AW:0] depthW = DEPTH[AW:0];

    wire wrStart = regWr && regAddr == `PIC_ADDR_START;
    wire wrDma = regWr && regAddr == `PIC_ADDR_DMA;
    wire wrCfg = regWr && regAddr == `PIC_ADDR_CFG;
    wire wrTpa = regWr && regAddr == `PIC_ADDR_TPA;
    wire wrErr = regWr && regAddr == `PIC_ADDR_ERR;
    wire softRst = wrCfg && regWdata == `PIC_SOFT_RESET;

    // word handshake on the link
    wire wordDone = pciRise && cs_q == `PIC_CS_DATA && pciIrdy_q && trdyS2;
    wire txPush = txValid & txReady_q;
    wire txPop = wordDone & isDma_q & isWrite_q;
    wire rxPush = wordDone & isDma_q & ~isWrite_q;
    wire rxPop = rxValid_q & rxReady;
    wire busy = cs_q != `PIC_CS_IDLE;

    // reset release and pin synchronisers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstS1 <= 1'b0;
            rstS2 <= 1'b0;
        end else begin
            rstS1 <= 1'b1;
            rstS2 <= rstS1;
        end
    end

    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            clkS1 <= 1'b0;
            clkS2 <= 1'b0;
            clkS3 <= 1'b0;
            trdyS1 <= 1'b0;
            trdyS2 <= 1'b0;
            sysS1 <= 1'b0;
            sysS2 <= 1'b0;
            adS1 <= 32'h00000000;
            adS2 <= 32'h00000000;
        end else begin
            clkS1 <= pciClk;
            clkS2 <= clkS1;
            clkS3 <= clkS2;
            trdyS1 <= pciTrdy;
            trdyS2 <= trdyS1;
            sysS1 <= sysEnPin;
            sysS2 <= sysS1;
            adS1 <= pciAdIn;
            adS2 <= adS1;
        end
    end

    // queue occupancy
    always @* begin
        txCnt_d = txCnt_q;
        rxCnt_d = rxCnt_q;
        if (txPush && !txPop) txCnt_d = txCnt_q + {{AW{1'b0}}, 1'b1};
        if (!txPush && txPop) txCnt_d = txCnt_q - {{AW{1'b0}}, 1'b1};
        if (rxPush && !rxPop) rxCnt_d = rxCnt_q + {{AW{1'b0}}, 1'b1};
        if (!rxPush && rxPop) rxCnt_d = rxCnt_q - {{AW{1'b0}}, 1'b1};
    end

    // queue storage
    always @(posedge mclk) begin
        if (txPush) txMem[txWp_q] <= txData;
        if (rxPush) rxMem[rxWp_q] <= adS2;
    end

    // queue pointers and flags
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txWp_q <= {AW{1'b0}};
            txRp_q <= {AW{1'b0}};
            rxWp_q <= {AW{1'b0}};
            rxRp_q <= {AW{1'b0}};
            txCnt_q <= {(AW+1){1'b0}};
            rxCnt_q <= {(AW+1){1'b0}};
            txReady_q <= 1'b0;
            rxValid_q <= 1'b0;
            rxData_q <= 32'h00000000;
        end else if (softRst) begin
            txWp_q <= {AW{1'b0}};
            txRp_q <= {AW{1'b0}};
            rxWp_q <= {AW{1'b0}};
            rxRp_q <= {AW{1'b0}};
            txCnt_q <= {(AW+1){1'b0}};
            rxCnt_q <= {(AW+1){1'b0}};
            txReady_q <= 1'b0;
            rxValid_q <= 1'b0;
        end else begin
            if (txPush) txWp_q <= txWp_q + {{(AW-1){1'b0}}, 1'b1};
            if (txPop) txRp_q <= txRp_q + {{(AW-1){1'b0}}, 1'b1};
            if (rxPush) rxWp_q <= rxWp_q + {{(AW-1){1'b0}}, 1'b1};
            if (rxPop) rxRp_q <= rxRp_q + {{(AW-1){1'b0}}, 1'b1};
            txCnt_q <= txCnt_d;
            rxCnt_q <= rxCnt_d;
            txReady_q <= txCnt_d != depthW;
            // head word loaded when the queue starts or advances
            rxValid_q <= rxCnt_d != {(AW+1){1'b0}} && !(rxPop && rxValid_q && !rxPush
                && rxCnt_q == {{AW{1'b0}}, 1'b1}) && !(rxValid_q && rxPop);
            if (!rxValid_q || rxPop) begin
                if (rxPop) rxData_q <= rxMem[rxRp_q + {{(AW-1){1'b0}}, 1'b1}];
                else rxData_q <= rxPush && rxCnt_q == {(AW+1){1'b0}} ? adS2 : rxMem[rxRp_q];
            end
        end
    end

    // configuration registers
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            startAddr_q <= 32'h00000000;
            dmaCfg_q <= 32'h00000000;
            cmdHi_q <= `PIC_CFG_CMD_RST;
            mode_q <= `PIC_CFG_MODE_RST;
            tpa_q <= `PIC_TPA_RST;
            window1Page_q <= `PIC_PAGE1_RST;
        end else begin
            if (wrStart) startAddr_q <= regWdata;
            if (wrDma) dmaCfg_q <= {20'h00000, regWdata[11:0]};
            if (softRst) begin
                cmdHi_q <= `PIC_CFG_CMD_RST;
            end else if (wrCfg) begin
                cmdHi_q <= regWdata[`PIC_CFG_CMD_MSB:`PIC_CFG_CMD_LSB];
                mode_q <= regWdata[`PIC_CFG_MODE];
            end
            if (wrTpa) begin
                tpa_q <= regWdata & `PIC_TPA_MASK;
                window1Page_q <= regWdata[31:24];
            end
        end
    end

    // internal error flag, set wins over clear
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            initError_q <= 1'b0;
        end else if (softRst && (dmaPend_q || (busy && isDma_q))) begin
            initError_q <= 1'b1;
        end else if (wrErr && regWdata[0]) begin
            initError_q <= 1'b0;
        end
    end

    // link engine and request capture
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            cs_q <= `PIC_CS_IDLE;
            ds_q <= `PIC_DS_IDLE;
            dmaPend_q <= 1'b0;
            mmPend_q <= 1'b0;
            mmWr_q <= 1'b0;
            mmA_q <= 32'h00000000;
            mmD_q <= 32'h00000000;
            isDma_q <= 1'b0;
            isWrite_q <= 1'b0;
            left_q <= 8'h00;
            mmDone_q <= 1'b0;
            mmRdata_q <= 32'h00000000;
            pciFrame_q <= 1'b0;
            pciIrdy_q <= 1'b0;
            pciCmd_q <= 4'h0;
            pciAdOut_q <= 32'h00000000;
            pciAdOe_q <= 1'b0;
        end else if (softRst) begin
            cs_q <= `PIC_CS_IDLE;
            ds_q <= `PIC_DS_IDLE;
            dmaPend_q <= 1'b0;
            mmPend_q <= 1'b0;
            mmDone_q <= mmPend_q;
            pciFrame_q <= 1'b0;
            pciIrdy_q <= 1'b0;
            pciAdOe_q <= 1'b0;
        end else begin
            mmDone_q <= 1'b0;
            if (wrDma && mode_q && regWdata[7:0] != 8'h00 && !dmaPend_q && ds_q == `PIC_DS_IDLE) begin
                dmaPend_q <= 1'b1;
                ds_q <= `PIC_DS_ARM;
            end
            if (mmReq && !mmPend_q) begin
                mmPend_q <= 1'b1;
                mmWr_q <= mmWrite;
                mmA_q <= mmAddr;
                mmD_q <= mmWdata;
            end
            if (pciRise) begin
                case (cs_q)
                    `PIC_CS_IDLE: begin
                        if (dmaPend_q && mode_q) begin
                            cs_q <= `PIC_CS_ADDR;
                            ds_q <= `PIC_DS_RUN;
                            dmaPend_q <= 1'b0;
                            isDma_q <= 1'b1;
                            isWrite_q <= dmaCfg_q[`PIC_DMA_CMD_LSB];
                            pciCmd_q <= dmaCfg_q[`PIC_DMA_CMD_MSB:`PIC_DMA_CMD_LSB];
                            left_q <= dmaCfg_q[`PIC_DMA_CNT_MSB:`PIC_DMA_CNT_LSB];
                            pciAdOut_q <= startAddr_q;
                            pciFrame_q <= 1'b1;
                            pciAdOe_q <= 1'b1;
                        end else if (mmPend_q && mode_q) begin
                            cs_q <= `PIC_CS_ADDR;
                            isDma_q <= 1'b0;
                            isWrite_q <= mmWr_q;
                            pciCmd_q <= {cmdHi_q, mmWr_q ? `PIC_MM_STORE : `PIC_MM_LOAD};
                            left_q <= 8'h01;
                            pciAdOut_q <= mmA_q;
                            pciFrame_q <= 1'b1;
                            pciAdOe_q <= 1'b1;
                        end
                    end
                    `PIC_CS_ADDR: begin
                        cs_q <= `PIC_CS_DATA;
                        pciAdOe_q <= isWrite_q;
                    end
                    `PIC_CS_DATA: begin
                        if (wordDone) begin
                            pciIrdy_q <= 1'b0;
                            left_q <= left_q - 8'h01;
                            if (!isDma_q && !isWrite_q) mmRdata_q <= adS2;
                            if (left_q == 8'h01) begin
                                cs_q <= `PIC_CS_DONE;
                                pciFrame_q <= 1'b0;
                                pciAdOe_q <= 1'b0;
                            end
                        end else if (!pciIrdy_q) begin
                            if (!isDma_q) begin
                                pciIrdy_q <= 1'b1;
                                pciAdOut_q <= mmD_q;
                            end else if (isWrite_q && txCnt_q != {(AW+1){1'b0}}) begin
                                pciIrdy_q <= 1'b1;
                                pciAdOut_q <= txMem[txRp_q];
                            end else if (!isWrite_q && rxCnt_q != depthW) begin
                                pciIrdy_q <= 1'b1;
                            end
                        end
                    end
                    `PIC_CS_DONE: begin
                        cs_q <= `PIC_CS_IDLE;
                        if (isDma_q) ds_q <= `PIC_DS_IDLE;
                        else begin
                            mmPend_q <= 1'b0;
                            mmDone_q <= 1'b1;
                        end
                        isDma_q <= 1'b0;
                    end
                    default: cs_q <= `PIC_CS_IDLE;
                endcase
            end
        end
    end

    // register read port, data one cycle after the strobe
    // status has no write path
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            regRdata_q <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                `PIC_ADDR_START: regRdata_q <= startAddr_q;
                `PIC_ADDR_DMA: regRdata_q <= dmaCfg_q;
                `PIC_ADDR_STAT: begin
                    regRdata_q <= 32'h00000000;
                    regRdata_q[`PIC_ST_SYS] <= sysS2;
                    regRdata_q[11:8] <= ds_q;
                    regRdata_q[`PIC_ST_ACT] <= dmaPend_q | mmPend_q | busy;
                    regRdata_q[`PIC_ST_TXFULL] <= txCnt_q == depthW;
                    regRdata_q[`PIC_ST_TXEMPTY] <= txCnt_q == {(AW+1){1'b0}};
                    regRdata_q[`PIC_ST_RXEMPTY] <= rxCnt_q == {(AW+1){1'b0}};
                    regRdata_q[3:0] <= cs_q;
                end
                `PIC_ADDR_CFG: regRdata_q <= {24'h000000, cmdHi_q, 5'h00, mode_q};
                `PIC_ADDR_TPA: regRdata_q <= tpa_q;
                `PIC_ADDR_ERR: regRdata_q <= {31'h00000000, initError_q};
                default: regRdata_q <= 32'h00000000;
            endcase
        end else begin
            regRdata_q <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// [shared/pic_defs.vh]
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH

// register byte addresses
`define PIC_ADDR_START 32'h80000148
`define PIC_ADDR_DMA 32'h80000150
`define PIC_ADDR_STAT 32'h80000154
`define PIC_ADDR_CFG 32'h80000158
`define PIC_ADDR_TPA 32'h8000015C
`define PIC_ADDR_ERR 32'h80000170

// initiator configuration fields
`define PIC_CFG_MODE 0
`define PIC_CFG_CMD_LSB 6
`define PIC_CFG_CMD_MSB 7
`define PIC_CFG_CMD_RST 2'h1
`define PIC_CFG_MODE_RST 1'h0
`define PIC_SOFT_RESET 32'hFFFFFFFF

// dma configuration fields
`define PIC_DMA_CMD_LSB 8
`define PIC_DMA_CMD_MSB 11
`define PIC_DMA_CNT_LSB 0
`define PIC_DMA_CNT_MSB 7

// status fields
`define PIC_ST_SYS 12
`define PIC_ST_ACT 7
`define PIC_ST_TXFULL 6
`define PIC_ST_TXEMPTY 5
`define PIC_ST_RXEMPTY 4

// target page layout and reset value
`define PIC_TPA_MASK 32'hFF00FF00
`define PIC_TPA_RST 32'h40009000
`define PIC_PAGE1_RST 8'h40

// low command bits for memory-mapped accesses
`define PIC_MM_LOAD 2'h2
`define PIC_MM_STORE 2'h3

// controller states
`define PIC_CS_IDLE 4'h0
`define PIC_CS_ADDR 4'h1
`define PIC_CS_DATA 4'h2
`define PIC_CS_DONE 4'h3

// dma sequencer states
`define PIC_DS_IDLE 4'h0
`define PIC_DS_ARM 4'h1
`define PIC_DS_RUN 4'h2

`endif

// [verification/pic_initiator_chk.sv]
`include "pic_defs.vh"
`default_nettype none
module pic_initiator_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata_q,
    input wire logic mmReq,
    input wire logic mmWrite,
    input wire logic mmDone_q,
    input wire logic txValid,
    input wire logic txReady_q,
    input wire logic [7:0] window1Page_q,
    input wire logic initError_q,
    input wire logic pciFrame_q,
    input wire logic [3:0] pciCmd_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cmdCls_q;
    logic initEn_q, mmPend_q, mmStore_q, errClr_q;
    wire logic cfgWr = regWr && regAddr == `PIC_ADDR_CFG;
    wire logic softWr = cfgWr && regWdata == `PIC_SOFT_RESET;
    wire logic dmaWr = regWr && regAddr == `PIC_ADDR_DMA;
    wire logic statRd = regRd && regAddr == `PIC_ADDR_STAT;
    wire logic [7:0] topByte = regWdata[31:24];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // shadow of command class, enable, pending mapped access and error clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmdCls_q <= `PIC_CFG_CMD_RST;
            initEn_q <= 1'h0;
            mmPend_q <= 1'h0;
            mmStore_q <= 1'h0;
            errClr_q <= 1'h0;
        end else begin
            if (softWr) begin
                cmdCls_q <= `PIC_CFG_CMD_RST;
            end else if (cfgWr) begin
                cmdCls_q <= regWdata[7:6];
                initEn_q <= regWdata[0];
            end
            if (mmReq) begin
                mmPend_q <= 1'h1;
                mmStore_q <= mmWrite;
            end else if (mmDone_q) begin
                mmPend_q <= 1'h0;
            end
            errClr_q <= regWr && regAddr == `PIC_ADDR_ERR && regWdata[0];
        end
    end
    a_launch_dma: assert property (dmaWr && initEn_q && regWdata[7:0] != 8'h0 && !pciFrame_q
        |-> ##[1:16] pciFrame_q) else $error("dma burst did not start");
    a_act_bit: assert property (statRd && pciFrame_q |=> regRdata_q[7])
        else $error("active bit low during frame");
    a_tx_full: assert property (statRd && !pciFrame_q && !txValid
        |=> regRdata_q[6] == !txReady_q) else $error("full bit disagrees with ready");
    a_cs_busy: assert property (statRd && pciFrame_q |=> regRdata_q[3:0] != 4'h0)
        else $error("controller idle during frame");
    a_cmd_class: assert property ($rose(pciFrame_q) && mmPend_q |-> pciCmd_q[3:2] == cmdCls_q)
        else $error("class bits wrong");
    a_cmd_kind: assert property ($rose(pciFrame_q) && mmPend_q
        |-> pciCmd_q[1:0] == {1'h1, mmStore_q}) else $error("load or store bits wrong");
    a_dma_off: assert property (dmaWr && !initEn_q && !pciFrame_q && !mmPend_q
        |=> !pciFrame_q [*8]) else $error("disabled initiator started");
    a_soft_end: assert property (softWr |-> ##[1:16] !pciFrame_q)
        else $error("soft reset left frame up");
    a_soft_flush: assert property (softWr |=> ##[0:3] txReady_q)
        else $error("soft reset did not flush");
    a_err_hold: assert property ($fell(initError_q) |-> errClr_q)
        else $error("error flag dropped without clear");
    a_page_wr: assert property (regWr && regAddr == `PIC_ADDR_TPA
        |=> window1Page_q == $past(topByte)) else $error("page byte not updated");
    a_stat_ro: assert property (regWr && regAddr == `PIC_ADDR_STAT
        |=> $stable(window1Page_q) && $stable(initError_q)) else $error("status write changed state");
    a_done_pulse: assert property (mmDone_q |=> !mmDone_q) else $error("done pulse too long");
    c_soft: cover property (softWr && pciFrame_q);
    c_store: cover property ($rose(pciFrame_q) && mmPend_q && mmStore_q);
    c_busy_rd: cover property (statRd && pciFrame_q);
endmodule
bind pic_initiator_ctrl pic_initiator_chk u_chk (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q), .mmReq(mmReq),
    .mmWrite(mmWrite), .mmDone_q(mmDone_q), .txValid(txValid), .txReady_q(txReady_q),
    .window1Page_q(window1Page_q), .initError_q(initError_q), .pciFrame_q(pciFrame_q),
    .pciCmd_q(pciCmd_q));
`default_nettype wire

// [verification/pic_pci_target.sv]
`default_nettype none
module pic_pci_target #(
    parameter logic [31:0] BASE = 32'hA5000000
) (
    input wire logic pciClk,
    input wire logic pciFrame_q,
    input wire logic pciIrdy_q,
    input wire logic pciAdOe_q,
    input wire logic [31:0] pciAdOut_q,
    input wire logic stall,
    output logic pciTrdy,
    output logic [31:0] pciAdIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] readCnt_q = 32'h0;
    logic [31:0] shown_q = BASE;
    logic [31:0] wrLog [$];
    initial pciTrdy = 1'h0;
    // a word moves on a rise with both ready lines up: log writes, count reads
    always @(posedge pciClk) begin
        if (pciIrdy_q && pciTrdy && pciAdOe_q) begin
            wrLog.push_back(pciAdOut_q);
        end else if (pciIrdy_q && pciTrdy) begin
            readCnt_q <= readCnt_q + 32'h1;
        end
    end
    // ready and read data change on the fall so they are settled at the rise
    always @(negedge pciClk) begin
        pciTrdy <= pciFrame_q && pciIrdy_q && !stall;
        shown_q <= BASE + readCnt_q;
    end
    // released data lines show the inverse word, never a stale copy
    assign pciAdIn = pciTrdy ? shown_q : ~shown_q;
endmodule
`default_nettype wire

// [verification/test_pic_initiator_ctrl.sv]
`include "pic_defs.vh"
`default_nettype none
module test_pic_initiator_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BASE = 32'hA5000000;
    logic mclk = 1'h0, rst_b = 1'h0, pciClk = 1'h0, stall = 1'h0, sysEnPin = 1'h1;
    logic regWr = 1'h0, regRd = 1'h0, mmReq = 1'h0, mmWrite = 1'h0, txValid = 1'h0, rxReady = 1'h0;
    logic [31:0] regAddr = 32'h0, regWdata = 32'h0, mmAddr = 32'h0, mmWdata = 32'h0, txData = 32'h0;
    logic [31:0] regRdata_q, mmRdata_q, rxData_q, pciAdOut_q, pciAdIn, s;
    logic mmDone_q, txReady_q, rxValid_q, initError_q, pciFrame_q, pciIrdy_q, pciAdOe_q, pciTrdy;
    logic [7:0] window1Page_q;
    logic [3:0] pciCmd_q;
    logic [31:0] expWord = BASE;
    int errors = 0, total_checks = 0, cycles = 0;
    pic_initiator_ctrl #(.DEPTH(8), .AW(3)) DUT (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q), .mmReq(mmReq),
        .mmWrite(mmWrite), .mmAddr(mmAddr), .mmWdata(mmWdata), .mmDone_q(mmDone_q),
        .mmRdata_q(mmRdata_q), .txData(txData), .txValid(txValid), .txReady_q(txReady_q),
        .rxData_q(rxData_q), .rxValid_q(rxValid_q), .rxReady(rxReady), .window1Page_q(window1Page_q),
        .initError_q(initError_q), .pciClk(pciClk), .pciTrdy(pciTrdy), .pciAdIn(pciAdIn),
        .sysEnPin(sysEnPin), .pciFrame_q(pciFrame_q), .pciIrdy_q(pciIrdy_q), .pciCmd_q(pciCmd_q),
        .pciAdOut_q(pciAdOut_q), .pciAdOe_q(pciAdOe_q));
    pic_pci_target #(.BASE(BASE)) u_tgt (.pciClk(pciClk), .pciFrame_q(pciFrame_q),
        .pciIrdy_q(pciIrdy_q), .pciAdOe_q(pciAdOe_q), .pciAdOut_q(pciAdOut_q), .stall(stall),
        .pciTrdy(pciTrdy), .pciAdIn(pciAdIn));
    initial forever #12.5 mclk = ~mclk;
    initial forever #100 pciClk = ~pciClk;
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard: a run far beyond the expected length counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'h0;
        #1 d = regRdata_q;
    endtask
    task automatic rdChk(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask
    task automatic push(input logic [31:0] d);
        @(posedge mclk);
        txValid <= 1'h1;
        txData <= d;
        @(posedge mclk);
        txValid <= 1'h0;
    endtask
    // poll status until dma, active and controller fields are all idle
    task automatic waitIdle();
        logic [31:0] d;
        d = 32'hFFFFFFFF;
        for (int n = 0; n < 200 && (d & 32'h00000F8F) !== 32'h0; n++) rd(`PIC_ADDR_STAT, d);
    endtask
    // one mapped access; the initiator is always enabled before the request
    task automatic mapped(input logic [1:0] cls, input logic st);
        logic [31:0] d;
        d = {8'hD0, 6'h0, cls, 15'h0, st};
        wr(`PIC_ADDR_CFG, {24'h0, cls, 5'h0, 1'h1});
        @(posedge mclk);
        mmReq <= 1'h1;
        mmWrite <= st;
        mmAddr <= d;
        mmWdata <= ~d;
        @(posedge mclk);
        mmReq <= 1'h0;
        for (int n = 0; n < 100 && pciFrame_q !== 1'h1; n++) @(negedge mclk);
        chk("cmd", {28'h0, cls, 1'h1, st}, {28'h0, pciCmd_q});
        for (int n = 0; n < 200 && mmDone_q !== 1'h1; n++) @(negedge mclk);
        chk("done", 32'h1, {31'h0, mmDone_q});
        if (st) begin
            chk("wdata", ~d, u_tgt.wrLog.pop_front());
        end else begin
            chk("rdata", expWord, mmRdata_q);
            expWord++;
        end
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'h1;
        repeat (3) @(posedge mclk);
        // reset values, unmapped hole, read-only status, page byte
        rdChk("stat", `PIC_ADDR_STAT, 32'h00001030);
        rdChk("cfg", `PIC_ADDR_CFG, 32'h00000040);
        rdChk("tpa", `PIC_ADDR_TPA, `PIC_TPA_RST);
        rdChk("hole", 32'h80000160, 32'h0);
        wr(`PIC_ADDR_STAT, 32'hFFFFFFFF);
        rdChk("stat", `PIC_ADDR_STAT, 32'h00001030);
        wr(`PIC_ADDR_TPA, 32'h12345678);
        rdChk("tpa", `PIC_ADDR_TPA, 32'h12005600);
        chk("page", 32'h12, {24'h0, window1Page_q});
        wr(`PIC_ADDR_START, 32'h00001000);
        rdChk("start", `PIC_ADDR_START, 32'h00001000);
        for (int c = 0; c < 4; c++) begin
            mapped(c[1:0], 1'h0);
            mapped(c[1:0], 1'h1);
        end
        // fill the transmit queue, then burst all eight words out
        for (int i = 0; i < 8; i++) push(32'hB0 + i);
        rdChk("full", `PIC_ADDR_STAT, 32'h00001050);
        wr(`PIC_ADDR_DMA, 32'h00000708);
        rd(`PIC_ADDR_STAT, s);
        chk("act", 32'h80, s & 32'h80);
        waitIdle();
        rdChk("idle", `PIC_ADDR_STAT, 32'h00001030);
        chk("count", 32'h8, u_tgt.wrLog.size());
        for (int i = 0; i < 8; i++) chk("word", 32'hB0 + i, u_tgt.wrLog.pop_front());
        // read burst of three words, then drain the receive queue
        wr(`PIC_ADDR_DMA, 32'h00000603);
        waitIdle();
        rdChk("rxfill", `PIC_ADDR_STAT, 32'h00001020);
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            // the head word is reloaded for a cycle after each pop
            for (int n = 0; n < 4 && rxValid_q !== 1'h1; n++) @(negedge mclk);
            chk("rxv", 32'h1, {31'h0, rxValid_q});
            chk("rx", expWord, rxData_q);
            expWord++;
            @(posedge mclk);
            rxReady <= 1'h1;
            @(posedge mclk);
            rxReady <= 1'h0;
        end
        @(negedge mclk);
        chk("rxv", 32'h0, {31'h0, rxValid_q});
        // zero count and disabled initiator start nothing
        wr(`PIC_ADDR_DMA, 32'h00000600);
        rdChk("zero", `PIC_ADDR_STAT, 32'h00001030);
        wr(`PIC_ADDR_CFG, 32'h00000040);
        wr(`PIC_ADDR_DMA, 32'h00000603);
        repeat (40) @(posedge mclk);
        rdChk("off", `PIC_ADDR_STAT, 32'h00001030);
        // soft reset in the middle of a stalled write burst
        wr(`PIC_ADDR_CFG, 32'h000000C1);
        push(32'hE0);
        stall <= 1'h1;
        wr(`PIC_ADDR_DMA, 32'h00000705);
        repeat (30) @(posedge mclk);
        rd(`PIC_ADDR_STAT, s);
        chk("busy", 32'h00001292, s);
        wr(`PIC_ADDR_CFG, `PIC_SOFT_RESET);
        rdChk("cfg", `PIC_ADDR_CFG, 32'h00000041);
        chk("ierr", 32'h1, {31'h0, initError_q});
        waitIdle();
        rdChk("flushed", `PIC_ADDR_STAT, 32'h00001030);
        rdChk("err", `PIC_ADDR_ERR, 32'h1);
        wr(`PIC_ADDR_ERR, 32'h1);
        rdChk("errclr", `PIC_ADDR_ERR, 32'h0);
        stall <= 1'h0;
        chk("nolog", 32'h0, u_tgt.wrLog.size());
        stop_test();
    end
endmodule
`default_nettype wire
